// [design/csf_pkg.sv]
// constants, field layouts and types shared by the status flag bank
package csf_pkg;

  // register port geometry
  localparam int CSF_ADDR_W = 4;
  localparam int CSF_DATA_W = 16;
  localparam int CSF_NPROG  = 3;

  // register offsets (word index on the register port)
  localparam logic [3:0] CSF_OFF_ERR  = 4'h0;
  localparam logic [3:0] CSF_OFF_PRG  = 4'h1;
  localparam logic [3:0] CSF_OFF_SYS  = 4'h2;
  localparam logic [3:0] CSF_OFF_RES1 = 4'h3;
  localparam logic [3:0] CSF_OFF_RES2 = 4'h4;
  localparam logic [3:0] CSF_OFF_RES3 = 4'h5;
  localparam logic [3:0] CSF_OFF_CTRL = 4'h6;
  localparam logic [3:0] CSF_OFF_UDC1 = 4'h7;
  localparam logic [3:0] CSF_OFF_UDC2 = 4'h8;

  // error register fields
  localparam int CSF_ERR_PWR     = 0;
  localparam int CSF_ERR_MEM     = 1;
  localparam int CSF_ERR_SPECIAL = 2;
  localparam int CSF_ERR_IOMOD   = 3;
  localparam int CSF_ERR_USER    = 4;
  localparam int CSF_ERR_UNCHK   = 5;
  localparam int CSF_ERR_VERIFY  = 6;
  localparam int CSF_ERR_SCAN    = 7;
  localparam int CSF_ERR_LATCH   = 8;
  localparam int CSF_ERR_BATT    = 9;

  // per-program error register fields (base of each 3-bit group)
  localparam int CSF_PRG_USER = 0;
  localparam int CSF_PRG_PARM = 4;
  localparam int CSF_PRG_SCAN = 8;

  // system register fields
  localparam int CSF_SYS_ONE   = 0;
  localparam int CSF_SYS_ZERO  = 1;
  localparam int CSF_SYS_FIRST = 2;
  localparam int CSF_SYS_SPEND = 3;
  localparam int CSF_SYS_SSTOP = 4;
  localparam int CSF_SYS_STOP  = 5;
  localparam int CSF_SYS_SCLK  = 6;
  localparam int CSF_SYS_UDC   = 7;
  localparam int CSF_SYS_TCLK  = 9;

  // command result register fields
  localparam int CSF_RES_ERR    = 0;
  localparam int CSF_RES_LT     = 1;
  localparam int CSF_RES_EQ     = 2;
  localparam int CSF_RES_GT     = 3;
  localparam int CSF_RES_Z      = 4;
  localparam int CSF_RES_BORROW = 5;
  localparam int CSF_RES_CARRY  = 6;
  localparam int CSF_RES_W      = 7;

  // control register fields
  localparam int CSF_CTRL_RELAY = 0;
  localparam int CSF_CTRL_ERST  = 1;
  localparam int CSF_CTRL_PCLR  = 2;

  // reset values
  localparam logic [15:0] CSF_RST_ZERO = 16'h0000;
  localparam logic [15:0] CSF_RST_UDC  = 16'h0101;

  // timing: a 1 ms tick drives the square-wave flags
  localparam longint CSF_CLK_HZ      = 125000000;
  localparam int     CSF_TICK_MS     = 1;
  localparam int     CSF_TICK_CYCLES = int'((CSF_CLK_HZ * CSF_TICK_MS) / 1000);
  localparam int     CSF_NTCLK       = 5;
  // half periods of the 0.1 s, 0.2 s, 1 s, 2 s and 60 s flags
  localparam int     CSF_HALF_MS [CSF_NTCLK] = '{50, 100, 500, 1000, 30000};

  // user-defined clock phase
  typedef enum logic [1:0] {
    CSF_UDC_HIGH = 2'b01,
    CSF_UDC_LOW  = 2'b10
  } csf_udc_state_t;

endpackage

// [design/csf_square_gen.sv]
// free-running 50 percent square wave, counted in ticks
`timescale 1ns/1ps
module csf_square_gen
  import csf_pkg::*;
#(
  parameter int HALF_TICKS = 50
)
(
  // clock and reset
  input  wire logic clk,
  input  wire logic rst,
  // time base
  input  wire logic tick,
  // wave out
  output logic      wave
);

  localparam int CW = $clog2(HALF_TICKS + 1);
  localparam logic [CW-1:0] LAST = CW'(HALF_TICKS - 1);

  logic [CW-1:0] cnt_reg;

  // count ticks, flip the level every half period
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      cnt_reg <= '0;
      wave    <= 1'b0;
    end
    else if (tick)
    begin
      if (cnt_reg == LAST)
      begin
        cnt_reg <= '0;
        wave    <= ~wave;
      end
      else
        cnt_reg <= cnt_reg + 1'b1;
    end
  end

endmodule

// [design/csf_flag_bank.sv]
// controller status flag bank: sticky faults, scan flags, result flags, clocks
//
// The placing of the registers and the address-and-strobe port were left to the implementer.
`timescale 1ns/1ps

// Function
// (RL1) power-loss flag sets on power failure, holds until reset
// (RL2) memory data error flag sets on corrupted program or parameter data
// (RL3) special-module error flag sets on fault, clears only by error reset
// (RL4) I/O module error flag sets on fault, clears only by error reset
// (RL5) user-program error flag sets on program fault, clears by error reset
// (RL6) data-unchecked flag sets on memory error, cleared by relay or peripheral
// (RL7) one user-program error flag per program, set by its own errors
// (RL8) one parameter error flag per program, set by its parameter errors
// (RL9) I/O verification flag sets when fitted modules differ from parameters
// (RL10) global scan-overrun flag sets on overrun, clears only by reset
// (RL11) program 1 command error latches, cleared by reset or writing zero
// (RL12) per-program scan-overrun flags, cleared only by reset
// (RL13) battery error flag sets on fault, clears only by error reset
// (RL14) one flag always reads one, another always reads zero
// (RL15) first-scan flag high from reset until end of first scan
// (RL16) stop-pending and simulated-stopped flags set by request/execution, reset clears
// (RL17) stopped flag low while scanning, high when stopped or stepping
// (RL18) per-program command error follows outcome of confined commands
// (RL19) comparison updates less, equal and greater flags
// (RL20) computation updates zero, borrow and carry flags
// (RL21) square-wave flags with periods 0.1, 0.2, 1, 2, 60 seconds
// (RL22) scan-clock flag toggles at every scan end
// (RL23) program clears data-unchecked alarm by raising error-clear relay
// (RL24) user clocks: high n scans, low m scans, counts loaded by command
// (RL25) errors with no clearing condition stay set until system reset
module csf_flag_bank
  import csf_pkg::*;
#(
  parameter int TICK_CYCLES = CSF_TICK_CYCLES
)
(
  // clock and reset (reset also stands for power re-application)
  input  wire logic                  clk,
  input  wire logic                  rst,
  // register port
  input  wire logic [CSF_ADDR_W-1:0] reg_addr,
  input  wire logic [CSF_DATA_W-1:0] reg_wdata,
  input  wire logic                  reg_wr,
  input  wire logic                  reg_rd,
  output logic      [CSF_DATA_W-1:0] reg_rdata,
  // fault detectors, one-cycle pulses
  input  wire logic                  power_fail_evt,
  input  wire logic                  mem_data_err_evt,
  input  wire logic                  special_err_evt,
  input  wire logic                  io_module_err_evt,
  input  wire logic                  user_prog_err_evt,
  input  wire logic                  io_verify_err_evt,
  input  wire logic                  battery_err_evt,
  input  wire logic [CSF_NPROG-1:0]  prog_err_evt,
  input  wire logic [CSF_NPROG-1:0]  param_err_evt,
  input  wire logic [CSF_NPROG-1:0]  scan_over_evt,
  // scan sequencer
  input  wire logic                  scan_end,
  input  wire logic                  stop_request,
  input  wire logic                  stop_exec,
  input  wire logic                  scan_running,
  input  wire logic                  step_mode,
  // applied command results
  input  wire logic [1:0]            cmd_prog,
  input  wire logic                  cmd_done,
  input  wire logic                  cmd_confined,
  input  wire logic                  cmd_fail,
  input  wire logic                  cmp_done,
  input  wire logic                  cmp_lt,
  input  wire logic                  cmp_eq,
  input  wire logic                  cmp_gt,
  input  wire logic                  calc_done,
  input  wire logic                  calc_zero,
  input  wire logic                  calc_neg,
  input  wire logic                  calc_over
);

  // write strobe aimed at one offset
  function automatic logic wr_hit(input logic [CSF_ADDR_W-1:0] a,
                                  input logic                  w,
                                  input logic [3:0]            off);
    return w && (a == off);
  endfunction

  localparam int TW = $clog2(TICK_CYCLES + 1);
  localparam logic [TW-1:0] TICK_LAST = TW'(TICK_CYCLES - 1);

  logic [CSF_DATA_W-1:0]    err_reg;
  logic [CSF_NPROG-1:0]     puser_reg;
  logic [CSF_NPROG-1:0]     pparm_reg;
  logic [CSF_NPROG-1:0]     pscan_reg;
  logic [CSF_RES_W-1:0]     res_reg [CSF_NPROG];
  logic                     relay_reg;
  logic                     first_reg;
  logic                     spend_reg;
  logic                     sstop_reg;
  logic                     stop_reg;
  logic                     sclk_reg;
  logic [1:0]               udc_wave;
  logic [CSF_DATA_W-1:0]    udc_cfg_reg [2];
  logic [CSF_NTCLK-1:0]     tclk;
  logic [TW-1:0]            tick_cnt_reg;
  logic                     tick;
  logic                     err_rst;
  logic                     per_clr;
  logic                     latch_wr0;
  logic [CSF_DATA_W-1:0]    rd_next;

  // error reset and peripheral clear are write-one pulses, never stored
  assign err_rst   = wr_hit(reg_addr, reg_wr, CSF_OFF_CTRL) && reg_wdata[CSF_CTRL_ERST];
  assign per_clr   = wr_hit(reg_addr, reg_wr, CSF_OFF_CTRL) && reg_wdata[CSF_CTRL_PCLR];
  assign latch_wr0 = wr_hit(reg_addr, reg_wr, CSF_OFF_ERR) && !reg_wdata[CSF_ERR_LATCH];

  // error-clear relay is a level held by the program
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      relay_reg <= 1'b0;
    else if (wr_hit(reg_addr, reg_wr, CSF_OFF_CTRL))
      relay_reg <= reg_wdata[CSF_CTRL_RELAY];
  end

  // global sticky faults; in every clear path a fresh event wins
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      err_reg <= CSF_RST_ZERO;
    else
    begin
      if (power_fail_evt)
        err_reg[CSF_ERR_PWR] <= 1'b1;                                  // RL1
      if (mem_data_err_evt)
        err_reg[CSF_ERR_MEM] <= 1'b1;                                  // RL2 RL25
      if (special_err_evt)
        err_reg[CSF_ERR_SPECIAL] <= 1'b1;                              // RL3
      else if (err_rst)
        err_reg[CSF_ERR_SPECIAL] <= 1'b0;                              // RL3
      if (io_module_err_evt)
        err_reg[CSF_ERR_IOMOD] <= 1'b1;                                // RL4
      else if (err_rst)
        err_reg[CSF_ERR_IOMOD] <= 1'b0;                                // RL4
      if (user_prog_err_evt)
        err_reg[CSF_ERR_USER] <= 1'b1;                                 // RL5
      else if (err_rst)
        err_reg[CSF_ERR_USER] <= 1'b0;                                 // RL5
      if (mem_data_err_evt)
        err_reg[CSF_ERR_UNCHK] <= 1'b1;                                // RL6
      else if (relay_reg || per_clr)
        err_reg[CSF_ERR_UNCHK] <= 1'b0;                                // RL6 RL23
      if (io_verify_err_evt)
        err_reg[CSF_ERR_VERIFY] <= 1'b1;                               // RL9 RL25
      if (|scan_over_evt)
        err_reg[CSF_ERR_SCAN] <= 1'b1;                                 // RL10
      if (cmd_done && cmd_confined && cmd_fail && cmd_prog == 2'd0)
        err_reg[CSF_ERR_LATCH] <= 1'b1;                                // RL11
      else if (latch_wr0)
        err_reg[CSF_ERR_LATCH] <= 1'b0;                                // RL11
      if (battery_err_evt)
        err_reg[CSF_ERR_BATT] <= 1'b1;                                 // RL13
      else if (err_rst)
        err_reg[CSF_ERR_BATT] <= 1'b0;                                 // RL13
    end
  end

  // per-program faults; only reset clears them
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      puser_reg <= '0;
      pparm_reg <= '0;
      pscan_reg <= '0;
    end
    else
    begin
      puser_reg <= puser_reg | prog_err_evt;                           // RL7 RL25
      pparm_reg <= pparm_reg | param_err_evt;                          // RL8 RL25
      pscan_reg <= pscan_reg | scan_over_evt;                          // RL12
    end
  end

  // result flags per program; a command to program 3 index never aliases
  genvar gp;
  generate
    for (gp = 0; gp < CSF_NPROG; gp++)
    begin : g_prog
      logic sel;
      assign sel = (cmd_prog == 2'(gp));
      always_ff @(posedge clk or posedge rst)
      begin
        if (rst)
          res_reg[gp] <= '0;
        else if (sel)
        begin
          if (cmd_done && cmd_confined)
            res_reg[gp][CSF_RES_ERR] <= cmd_fail;                      // RL18
          if (cmp_done)
          begin
            res_reg[gp][CSF_RES_LT] <= cmp_lt;                         // RL19
            res_reg[gp][CSF_RES_EQ] <= cmp_eq;                         // RL19
            res_reg[gp][CSF_RES_GT] <= cmp_gt;                         // RL19
          end
          if (calc_done)
          begin
            res_reg[gp][CSF_RES_Z]  <= calc_zero;                      // RL20
            res_reg[gp][CSF_RES_BORROW] <= calc_neg;                   // RL20
            res_reg[gp][CSF_RES_CARRY]  <= calc_over;                  // RL20
          end
        end
      end
    end
  endgenerate

  // scan-state flags
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      first_reg <= 1'b1;                                               // RL15
      spend_reg <= 1'b0;
      sstop_reg <= 1'b0;
      stop_reg  <= 1'b1;
      sclk_reg  <= 1'b0;
    end
    else
    begin
      if (scan_end)
        first_reg <= 1'b0;                                             // RL15
      if (stop_request)
        spend_reg <= 1'b1;                                             // RL16
      if (stop_exec)
        sstop_reg <= 1'b1;                                             // RL16
      stop_reg <= !scan_running || step_mode;                          // RL17
      if (scan_end)
        sclk_reg <= ~sclk_reg;                                         // RL22
    end
  end

  // user-defined clocks: counts of zero are treated as one scan
  genvar gu;
  generate
    for (gu = 0; gu < 2; gu++)
    begin : g_udc
      csf_udc_state_t state_reg;
      logic [7:0]     cnt_reg;
      logic [7:0]     lim;
      always_comb
      begin
        lim = (state_reg == CSF_UDC_HIGH) ? udc_cfg_reg[gu][7:0] : udc_cfg_reg[gu][15:8];
      end
      always_ff @(posedge clk or posedge rst)
      begin
        if (rst)
          udc_cfg_reg[gu] <= CSF_RST_UDC;
        else if (wr_hit(reg_addr, reg_wr, 4'(CSF_OFF_UDC1 + 4'(gu))))
          udc_cfg_reg[gu] <= reg_wdata;                                // RL24
      end
      always_ff @(posedge clk or posedge rst)
      begin
        if (rst)
        begin
          state_reg <= CSF_UDC_HIGH;
          cnt_reg   <= '0;
        end
        else if (scan_end)
        begin
          if (cnt_reg + 8'd1 >= lim)
          begin
            cnt_reg <= '0;
            case (state_reg)
              CSF_UDC_HIGH: state_reg <= CSF_UDC_LOW;                  // RL24
              CSF_UDC_LOW:  state_reg <= CSF_UDC_HIGH;                 // RL24
              default:      state_reg <= CSF_UDC_HIGH;
            endcase
          end
          else
            cnt_reg <= cnt_reg + 8'd1;
        end
      end
      assign udc_wave[gu] = (state_reg == CSF_UDC_HIGH);
    end
  endgenerate

  // 1 ms time base shared by all square waves
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      tick_cnt_reg <= '0;
    else if (tick_cnt_reg == TICK_LAST)
      tick_cnt_reg <= '0;
    else
      tick_cnt_reg <= tick_cnt_reg + 1'b1;
  end
  assign tick = (tick_cnt_reg == TICK_LAST);

  // fixed-period square-wave flags
  genvar gt;
  generate
    for (gt = 0; gt < CSF_NTCLK; gt++)
    begin : g_tclk
      csf_square_gen #(
        .HALF_TICKS (CSF_HALF_MS[gt] / CSF_TICK_MS)
      ) u_sq (
        .clk  (clk),
        .rst  (rst),
        .tick (tick),
        .wave (tclk[gt])                                               // RL21
      );
    end
  endgenerate

  // read mux; unmapped offsets read zero, bits above each field read zero
  always_comb
  begin
    rd_next = '0;
    case (reg_addr)
      CSF_OFF_ERR:  rd_next = err_reg;
      CSF_OFF_PRG:
      begin
        rd_next[CSF_PRG_USER +: CSF_NPROG] = puser_reg;
        rd_next[CSF_PRG_PARM +: CSF_NPROG] = pparm_reg;
        rd_next[CSF_PRG_SCAN +: CSF_NPROG] = pscan_reg;
      end
      CSF_OFF_SYS:
      begin
        rd_next[CSF_SYS_ONE]   = 1'b1;                                 // RL14
        rd_next[CSF_SYS_ZERO]  = 1'b0;                                 // RL14
        rd_next[CSF_SYS_FIRST] = first_reg;
        rd_next[CSF_SYS_SPEND] = spend_reg;
        rd_next[CSF_SYS_SSTOP] = sstop_reg;
        rd_next[CSF_SYS_STOP]  = stop_reg;
        rd_next[CSF_SYS_SCLK]  = sclk_reg;
        rd_next[CSF_SYS_UDC +: 2]          = udc_wave;
        rd_next[CSF_SYS_TCLK +: CSF_NTCLK] = tclk;
      end
      CSF_OFF_RES1: rd_next[CSF_RES_W-1:0] = res_reg[0];
      CSF_OFF_RES2: rd_next[CSF_RES_W-1:0] = res_reg[1];
      CSF_OFF_RES3: rd_next[CSF_RES_W-1:0] = res_reg[2];
      CSF_OFF_CTRL: rd_next[CSF_CTRL_RELAY] = relay_reg;
      CSF_OFF_UDC1: rd_next = udc_cfg_reg[0];
      CSF_OFF_UDC2: rd_next = udc_cfg_reg[1];
      default:      rd_next = '0;
    endcase
  end

  // read data stands only in the cycle after the read strobe
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      reg_rdata <= '0;
    else if (reg_rd)
      reg_rdata <= rd_next;
    else
      reg_rdata <= '0;
  end

  // checks on the flag behaviour
  property p_pwr_hold;
    @(posedge clk) disable iff (rst)
    power_fail_evt |=> err_reg[CSF_ERR_PWR] [*8];
  endproperty
  a_pwr_hold: assert property (p_pwr_hold) else $error("power-loss flag dropped"); // RL1

  property p_mem_set;
    @(posedge clk) disable iff (rst)
    mem_data_err_evt |=> err_reg[CSF_ERR_MEM] && err_reg[CSF_ERR_UNCHK];
  endproperty
  a_mem_set: assert property (p_mem_set) else $error("memory error flags not set"); // RL2

  property p_special_clr;
    @(posedge clk) disable iff (rst)
    $fell(err_reg[CSF_ERR_SPECIAL]) |-> $past(err_rst) && !$past(special_err_evt);
  endproperty
  a_special_clr: assert property (p_special_clr) else $error("special flag cleared wrongly"); // RL3

  property p_batt_clr;
    @(posedge clk) disable iff (rst)
    err_rst && !battery_err_evt |=> !err_reg[CSF_ERR_BATT];
  endproperty
  a_batt_clr: assert property (p_batt_clr) else $error("battery flag not cleared"); // RL13

  property p_unchk_clr;
    @(posedge clk) disable iff (rst)
    $fell(err_reg[CSF_ERR_UNCHK]) |-> $past(relay_reg) || $past(per_clr);
  endproperty
  a_unchk_clr: assert property (p_unchk_clr) else $error("unchecked flag cleared wrongly"); // RL6

  property p_scan_sticky;
    @(posedge clk) disable iff (rst)
    scan_over_evt[0] |=> pscan_reg[0] && err_reg[CSF_ERR_SCAN] ##1 pscan_reg[0];
  endproperty
  a_scan_sticky: assert property (p_scan_sticky) else $error("scan overrun not held"); // RL12

  property p_latch_set;
    @(posedge clk) disable iff (rst)
    cmd_done && cmd_confined && cmd_fail && cmd_prog == 2'd0
      |=> err_reg[CSF_ERR_LATCH] && res_reg[0][CSF_RES_ERR];
  endproperty
  a_latch_set: assert property (p_latch_set) else $error("command error not latched"); // RL11

  property p_first;
    @(posedge clk) disable iff (rst)
    scan_end |=> !first_reg;
  endproperty
  a_first: assert property (p_first) else $error("first-scan flag not cleared"); // RL15

  property p_stop;
    @(posedge clk) disable iff (rst)
    scan_running && !step_mode |=> !stop_reg;
  endproperty
  a_stop: assert property (p_stop) else $error("stopped flag high while scanning"); // RL17

  property p_sclk;
    @(posedge clk) disable iff (rst)
    scan_end |=> sclk_reg != $past(sclk_reg);
  endproperty
  a_sclk: assert property (p_sclk) else $error("scan clock did not toggle"); // RL22

  property p_calc;
    @(posedge clk) disable iff (rst)
    calc_done && cmd_prog == 2'd1 |=> res_reg[1][CSF_RES_BORROW] == $past(calc_neg)
      && res_reg[1][CSF_RES_CARRY] == $past(calc_over);
  endproperty
  a_calc: assert property (p_calc) else $error("computation flags wrong"); // RL20

endmodule

// [dv/csf_prog_model.sv]
// bus master model standing in for the sequence program and peripheral tools
`timescale 1ns/1ps
module csf_prog_model
  import csf_pkg::*;
(
  // clock
  input  wire logic                  clk,
  // register port
  output logic      [CSF_ADDR_W-1:0] reg_addr,
  output logic      [CSF_DATA_W-1:0] reg_wdata,
  output logic                       reg_wr,
  output logic                       reg_rd,
  input  wire logic [CSF_DATA_W-1:0] reg_rdata
);
  // idle bus at time zero
  initial
  begin
    reg_addr  = '0;
    reg_wdata = '0;
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
  end

  // one-cycle write; data inverted afterwards so a stale word never looks valid
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk);
    reg_wr    <= 1'b0;
    reg_wdata <= ~d;
  endtask

  // one-cycle read; data stands only in the following cycle, taken at the edge closing it
  task automatic rd(input logic [3:0] a, output logic [15:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk);
    reg_rd   <= 1'b0;
    @(posedge clk);
    d = reg_rdata;
  endtask

  // program acknowledges the unchecked data alarm by pulsing the relay
  task automatic clear_relay;
    wr(CSF_OFF_CTRL, 16'h0001);
    wr(CSF_OFF_CTRL, 16'h0000);
  endtask
endmodule

// [dv/csf_flag_bank_tb.sv]
// self-checking bench for the controller status flag bank
`timescale 1ns/1ps
module csf_flag_bank_tb;
  import csf_pkg::*;
  logic clk = 0, rst = 1;
  logic [3:0] reg_addr;
  logic [15:0] reg_wdata, reg_rdata, v;
  logic reg_wr, reg_rd;
  logic power_fail_evt, mem_data_err_evt, special_err_evt, io_module_err_evt;
  logic user_prog_err_evt, io_verify_err_evt, battery_err_evt;
  logic [2:0] prog_err_evt, param_err_evt, scan_over_evt;
  logic scan_end, stop_request, stop_exec, scan_running, step_mode;
  logic [1:0] cmd_prog;
  logic cmd_done, cmd_confined, cmd_fail, cmp_done, cmp_lt, cmp_eq, cmp_gt;
  logic calc_done, calc_zero, calc_neg, calc_over;
  int n_fail = 0, cmp_count = 0, cyc = 0;

  // short tick so the 0.1 s flag has a 200-cycle half period
  csf_flag_bank #(.TICK_CYCLES(4)) DUT (.clk, .rst, .reg_addr, .reg_wdata, .reg_wr,
    .reg_rd, .reg_rdata, .power_fail_evt, .mem_data_err_evt, .special_err_evt,
    .io_module_err_evt, .user_prog_err_evt, .io_verify_err_evt, .battery_err_evt,
    .prog_err_evt, .param_err_evt, .scan_over_evt, .scan_end, .stop_request,
    .stop_exec, .scan_running, .step_mode, .cmd_prog, .cmd_done, .cmd_confined,
    .cmd_fail, .cmp_done, .cmp_lt, .cmp_eq, .cmp_gt, .calc_done, .calc_zero,
    .calc_neg, .calc_over);
  csf_prog_model prog (.clk, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata);

  // clock and cycles since reset release
  initial
  begin
    forever #4 clk = ~clk;
  end
  always @(posedge clk) cyc <= rst ? 0 : cyc + 1;

  // read a word and compare the masked bits
  task automatic chk(input logic [3:0] a, input logic [15:0] e, input logic [15:0] m);
    prog.rd(a, v);
    cmp_count++;
    if ((v & m) !== (e & m))
    begin
      n_fail++;
      $display("[FAIL] %0t word %0h read %h expected %h", $time, a, v, e);
    end
  endtask

  task automatic tally_and_finish;
    $display("mismatches %0d comparisons %0d", n_fail, cmp_count);
    if (n_fail == 0 && cmp_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // one-cycle pulse on the command result inputs of one program
  task automatic cmd(input logic [1:0] p, input logic [6:0] f);
    @(posedge clk);
    cmd_prog <= p;
    {cmd_done, cmd_confined, cmp_done, calc_done} <= 4'hF;
    {cmd_fail, cmp_lt, cmp_eq, cmp_gt, calc_zero, calc_neg, calc_over} <= f;
    @(posedge clk);
    {cmd_done, cmd_confined, cmp_done, calc_done} <= 4'h0;
  endtask

  task automatic t_reset;
    chk(CSF_OFF_SYS, 16'h01A5, 16'h01FF);
    chk(CSF_OFF_UDC1, CSF_RST_UDC, 16'hFFFF);
    prog.wr(CSF_OFF_SYS, 16'h0000);
    chk(CSF_OFF_SYS, 16'h01A5, 16'h01FF);
    chk(4'hF, 16'h0000, 16'hFFFF);
  endtask

  // every global detector fires once, then error reset and relay clear
  task automatic t_errors;
    @(posedge clk);
    {power_fail_evt, mem_data_err_evt, special_err_evt, io_module_err_evt} <= 4'hF;
    {user_prog_err_evt, io_verify_err_evt, battery_err_evt} <= 3'h7;
    @(posedge clk);
    {power_fail_evt, mem_data_err_evt, special_err_evt, io_module_err_evt} <= 4'h0;
    {user_prog_err_evt, io_verify_err_evt, battery_err_evt} <= 3'h0;
    chk(CSF_OFF_ERR, 16'h027F, 16'hFFFF);
    prog.wr(CSF_OFF_CTRL, 16'h0002);
    chk(CSF_OFF_ERR, 16'h0063, 16'hFFFF);
    prog.clear_relay();
    chk(CSF_OFF_ERR, 16'h0043, 16'hFFFF);
  endtask

  task automatic t_prog;
    @(posedge clk);
    {prog_err_evt, param_err_evt, scan_over_evt} <= {3'b101, 3'b010, 3'b101};
    @(posedge clk);
    {prog_err_evt, param_err_evt, scan_over_evt} <= '0;
    chk(CSF_OFF_PRG, 16'h0525, 16'hFFFF);
    chk(CSF_OFF_ERR, 16'h0080, 16'h0080);
  endtask

  task automatic t_cmd;
    for (int p = 0; p < 3; p++)
    begin
      cmd(p[1:0], 7'b1010001);
      chk(CSF_OFF_RES1 + p[3:0], 16'h0045, 16'h007F);
      cmd(p[1:0], 7'b0100100);
      chk(CSF_OFF_RES1 + p[3:0], 16'h0012, 16'h007F);
      cmd(p[1:0], 7'b0001010);
      chk(CSF_OFF_RES1 + p[3:0], 16'h0028, 16'h007F);
    end
    // a failing command without confinement must leave the error flag alone
    @(posedge clk);
    {cmd_done, cmd_fail} <= 2'b11;
    @(posedge clk);
    {cmd_done, cmd_fail} <= 2'b00;
    chk(CSF_OFF_RES3, 16'h0000, 16'h0001);
    chk(CSF_OFF_ERR, 16'h0100, 16'h0100);
    prog.wr(CSF_OFF_ERR, 16'h0000);
    chk(CSF_OFF_ERR, 16'h0000, 16'h0100);
  endtask

  task automatic t_scan;
    for (int i = 0; i < 2; i++)
    begin
      @(posedge clk);
      scan_end <= 1'b1;
      @(posedge clk);
      scan_end <= 1'b0;
      chk(CSF_OFF_SYS, i ? 16'h0180 : 16'h0040, 16'h01C4);
    end
    @(posedge clk);
    stop_request <= 1'b1;
    @(posedge clk);
    stop_request <= 1'b0;
    chk(CSF_OFF_SYS, 16'h0008, 16'h0018);
    @(posedge clk);
    stop_exec <= 1'b1;
    scan_running <= 1'b1;
    @(posedge clk);
    stop_exec <= 1'b0;
    chk(CSF_OFF_SYS, 16'h0018, 16'h0038);
    step_mode <= 1'b1;
    chk(CSF_OFF_SYS, 16'h0020, 16'h0020);
  endtask

  // mid-run reset, then the 0.1 s flag high and 0.2 s flag still low
  task automatic t_wave;
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    chk(CSF_OFF_SYS, 16'h0004, 16'h001C);
    chk(CSF_OFF_ERR, 16'h0000, 16'hFFFF);
    while (cyc < 300) @(posedge clk);
    chk(CSF_OFF_SYS, 16'h0200, 16'h0600);
  endtask

  initial
  begin
    {power_fail_evt, mem_data_err_evt, special_err_evt, io_module_err_evt} = '0;
    {user_prog_err_evt, io_verify_err_evt, battery_err_evt} = '0;
    {prog_err_evt, param_err_evt, scan_over_evt, cmd_prog} = '0;
    {scan_end, stop_request, stop_exec, scan_running, step_mode} = '0;
    {cmd_done, cmd_confined, cmd_fail, cmp_done, cmp_lt, cmp_eq, cmp_gt} = '0;
    {calc_done, calc_zero, calc_neg, calc_over} = '0;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_errors();
    t_prog();
    t_cmd();
    t_scan();
    t_wave();
    tally_and_finish();
  end

  // watchdog well beyond the few hundred cycles the tests need
  initial
  begin
    #200000;
    n_fail++;
    tally_and_finish();
  end
endmodule
